// ### include/pw_encap_pkg.sv
/*
 * Constants for the pseudowire encapsulation framer: register map, control
 * word fields, RTP header fields, circuit rates and sizes.
 * Assumes a single 250 MHz clock and a plain strobe-based register port.
 */
`default_nettype none
package pw_encap_pkg;
    // Register byte addresses, spaced four apart
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_PAYLOAD  = 8'h04;
    localparam logic [7:0] REG_MTU      = 8'h08;
    localparam logic [7:0] REG_RTP_ID   = 8'h0C;
    localparam logic [7:0] REG_SEQ      = 8'h10;
    localparam logic [7:0] REG_STATUS   = 8'h14;
    localparam logic [7:0] REG_PKTCNT   = 8'h18;
    // Control register fields
    localparam int CTRL_EN        = 0;
    localparam int CTRL_RTP       = 1;
    localparam int CTRL_DEMUX_LSB = 2;
    localparam int CTRL_RATE_LSB  = 4;
    localparam int CTRL_LBIT      = 6;
    localparam int CTRL_RBIT      = 7;
    localparam int CTRL_ACH_LSB   = 8;
    localparam int CTRL_ACH_EN    = 12;
    localparam int CTRL_IPV4      = 13;
    localparam int CTRL_PT_LSB    = 16;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [15:0] PAYLOAD_RESET = 16'h0100;
    localparam logic [15:0] MTU_RESET     = 16'h05DC;
    // Header sizes in bytes
    localparam logic [15:0] CW_BYTES      = 16'h0004;
    localparam logic [15:0] RTP_BYTES     = 16'h000C;
    localparam logic [15:0] SHORT_LIMIT   = 16'h0040;
    localparam logic [15:0] OUTER_BYTES   = 16'h001C;
    // Alarm pattern byte for framing-agnostic circuits
    localparam logic [7:0]  ALARM_BYTE    = 8'hFF;
    localparam logic [1:0]  RTP_VERSION   = 2'h2;
    // Circuit rates in kbit/s
    localparam int RATE_E1_KBPS = 2048;
    localparam int RATE_T1_KBPS = 1544;
    localparam int RATE_E3_KBPS = 34368;
    localparam int RATE_T3_KBPS = 44736;
    typedef enum logic [1:0] {DEMUX_UDP = 2'h0, DEMUX_L2TP = 2'h1, DEMUX_MPLS = 2'h2}
        demux_t;
    typedef enum logic [1:0] {RATE_E1 = 2'h0, RATE_T1 = 2'h1, RATE_E3 = 2'h2,
        RATE_T3 = 2'h3} rate_t;
endpackage
`default_nettype wire

// ### include/pw_hdr_if.sv
/*
 * Interface carrying header configuration from the framer core to the
 * header word builder. Assumes both ends share ref_clk.
 */
`default_nettype none
interface pw_hdr_if;
    logic        rtp_on;
    logic [1:0]  demux;
    logic        lbit;
    logic        rbit;
    logic        ach_en;
    logic [3:0]  ach_nibble;
    logic [15:0] total_len;
    logic [15:0] seq;
    logic [6:0]  pt;
    logic [31:0] ssrc;
    logic [31:0] tstamp;
    logic [2:0]  word_idx;
    logic [31:0] word;
    logic [2:0]  hdr_words;
    modport core (output rtp_on, demux, lbit, rbit, ach_en, ach_nibble, total_len,
        seq, pt, ssrc, tstamp, word_idx, input word, hdr_words);
    modport build (input rtp_on, demux, lbit, rbit, ach_en, ach_nibble, total_len,
        seq, pt, ssrc, tstamp, word_idx, output word, hdr_words);
endinterface
`default_nettype wire

// ### design/pw_hdr_builder.sv
/*
 * Header word builder: returns one 32-bit header word by index, placing the
 * RTP header before or after the control word according to demux type.
 * Assumes indices below hdr_words only are requested.
 */
`default_nettype none
module pw_hdr_builder (
    pw_hdr_if.build h
);
    logic [31:0] cw;
    logic [31:0] rtp0;
    logic [5:0]  short_size_field;

    // Short size only fits below 64 bytes, zero otherwise
    always_comb begin
        short_size_field = (h.total_len < pw_encap_pkg::SHORT_LIMIT) ?
            h.total_len[5:0] : 6'h00;
        cw = {(h.ach_en ? h.ach_nibble : 4'h0),
              h.lbit, h.rbit,
              4'h0,
              short_size_field, h.seq};
        rtp0 = {pw_encap_pkg::RTP_VERSION, 1'b0, 1'b0, 4'h0, 1'b0, h.pt, h.seq};
    end

    // Word order: UDP puts RTP first, L2TPv3/MPLS put it after the control word
    always_comb begin
        h.hdr_words = h.rtp_on ? 3'h4 : 3'h1;
        h.word = cw;
        if (h.rtp_on && h.demux == pw_encap_pkg::DEMUX_UDP) begin
            case (h.word_idx)
                3'h0: h.word = rtp0;
                3'h1: h.word = h.tstamp;
                3'h2: h.word = h.ssrc;
                default: h.word = cw;
            endcase
        end else if (h.rtp_on) begin
            case (h.word_idx)
                3'h0: h.word = cw;
                3'h1: h.word = rtp0;
                3'h2: h.word = h.tstamp;
                default: h.word = h.ssrc;
            endcase
        end
    end
endmodule // pw_hdr_builder
`default_nettype wire

// ### design/alarm_detect.sv
/*
 * All-ones alarm pattern detector over incoming payload bytes. Runs only for
 * framing-agnostic circuit rates; for the framed high rate it stays idle.
 * Assumes bytes arrive from logic on the same clock.
 */
`default_nettype none
module alarm_detect (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic       pkt_end,
    output logic            alarm_seen
);
    logic run_ones;
    logic next_run_ones;
    logic next_alarm_seen;

    // A packet is an alarm packet only if every byte was all ones
    always_comb begin
        next_run_ones   = run_ones;
        next_alarm_seen = alarm_seen;
        if (!enable) begin
            next_run_ones   = 1'b1; // Re-arm, so the first packet after T3 is judged whole
            next_alarm_seen = 1'b0;
        end else begin
            if (byte_valid) begin
                next_run_ones = run_ones & (byte_data == pw_encap_pkg::ALARM_BYTE);
            end
            if (pkt_end) begin
                next_alarm_seen = next_run_ones;
                next_run_ones   = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_ones   <= 1'b1;
            alarm_seen <= 1'b0;
        end else begin
            run_ones   <= next_run_ones;
            alarm_seen <= next_alarm_seen;
        end
    end
endmodule // alarm_detect
`default_nettype wire

// ### design/pw_encapsulator.sv
/*
 * Structure-agnostic pseudowire encapsulation framer, packet-bound direction.
 * Collects TDM payload bytes, emits header words then payload as a 32-bit
 * stream with valid/ready, and refuses packets that would exceed the MTU.
 * Assumes payload bytes arrive from a native service processor on ref_clk,
 * and the packet side holds tx_ready as a plain handshake.
 */
// Implementation choices: the register offsets and the strobed register port.
`default_nettype none
module pw_encapsulator (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        tdm_valid,
    input  wire logic [7:0]  tdm_byte,
    output logic             tdm_ready,
    input  wire logic [31:0] tstamp_in,
    output logic             tx_valid,
    output logic [31:0]      tx_data,
    output logic             tx_first,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic             dont_fragment,
    output logic             alarm_detected
);
    typedef enum logic [1:0] {ST_FILL = 2'h0, ST_HDR = 2'h1, ST_PAY = 2'h3,
        ST_DROP = 2'h2} state_t;

    localparam int MAX_WORDS = 256;

    // Packet payload store, one frame deep; bits kept in arrival order
    logic [31:0] pay_mem [MAX_WORDS];

    logic [31:0] ctrl;
    logic [15:0] payload_len;
    logic [15:0] mtu;
    logic [31:0] ssrc;
    logic [15:0] seq;
    logic [15:0] pkt_cnt;
    logic [15:0] drop_cnt;
    logic [31:0] next_ctrl;
    logic [15:0] next_payload_len;
    logic [15:0] next_mtu;
    logic [31:0] next_ssrc;
    logic [15:0] next_seq;
    logic [15:0] next_pkt_cnt;
    logic [15:0] next_drop_cnt;
    logic        rd_pend;
    logic [7:0]  rd_addr_q;

    state_t      state;
    state_t      next_state;
    logic [15:0] fill_cnt;
    logic [15:0] next_fill_cnt;
    logic [23:0] shreg;
    logic [23:0] next_shreg;
    logic [7:0]  rd_ptr;
    logic [7:0]  next_rd_ptr;
    logic [2:0]  hidx;
    logic [2:0]  next_hidx;
    logic [31:0] tstamp_q;
    logic [31:0] next_tstamp_q;
    logic        wr_en;
    logic [7:0]  wr_ptr;
    logic [31:0] wr_word;
    logic        pkt_done;
    logic [15:0] hdr_bytes;
    logic [15:0] pkt_bytes;
    logic [15:0] pay_words;
    logic        fits_mtu;
    logic        alarm_ok;

    pw_hdr_if hdr ();

    // Register write decode helper, used for each writable register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // Whole packet length: outer demux headers plus pw header plus payload
    always_comb begin
        hdr_bytes = pw_encap_pkg::CW_BYTES
            + (ctrl[pw_encap_pkg::CTRL_RTP] ? pw_encap_pkg::RTP_BYTES : 16'h0000);
        pkt_bytes = hdr_bytes + payload_len;
        fits_mtu  = (pkt_bytes + pw_encap_pkg::OUTER_BYTES) <= mtu;
        pay_words = (payload_len + 16'h0003) >> 2;
        alarm_ok  = ctrl[pw_encap_pkg::CTRL_RATE_LSB +: 2] != pw_encap_pkg::RATE_T3;
    end

    // Header builder connections
    assign hdr.rtp_on     = ctrl[pw_encap_pkg::CTRL_RTP];
    assign hdr.demux      = ctrl[pw_encap_pkg::CTRL_DEMUX_LSB +: 2];
    assign hdr.lbit       = ctrl[pw_encap_pkg::CTRL_LBIT];
    assign hdr.rbit       = ctrl[pw_encap_pkg::CTRL_RBIT];
    assign hdr.ach_en     = ctrl[pw_encap_pkg::CTRL_ACH_EN];
    assign hdr.ach_nibble = ctrl[pw_encap_pkg::CTRL_ACH_LSB +: 4];
    assign hdr.total_len  = pkt_bytes;
    assign hdr.seq        = seq;
    assign hdr.pt         = ctrl[pw_encap_pkg::CTRL_PT_LSB +: 7];
    assign hdr.ssrc       = ssrc;
    assign hdr.tstamp     = tstamp_q;
    assign hdr.word_idx   = hidx;

    pw_hdr_builder u_hdr (
        .h (hdr)
    );

    alarm_detect u_alarm (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .enable     (alarm_ok),
        .byte_valid (tdm_valid && tdm_ready),
        .byte_data  (tdm_byte),
        .pkt_end    (pkt_done),
        .alarm_seen (alarm_detected)
    );

    // Don't-fragment marking whenever the network is IPv4
    assign dont_fragment = ctrl[pw_encap_pkg::CTRL_IPV4];

    // Payload is only taken while filling; stalls the circuit side otherwise
    assign tdm_ready = (state == ST_FILL) && ctrl[pw_encap_pkg::CTRL_EN];
    assign pkt_done  = tdm_valid && tdm_ready && (fill_cnt == payload_len - 16'h0001);

    // Register next values; software sees the live sequence number
    always_comb begin
        next_ctrl        = ctrl;
        next_payload_len = payload_len;
        next_mtu         = mtu;
        next_ssrc        = ssrc;
        next_seq         = seq;
        next_pkt_cnt     = pkt_cnt;
        next_drop_cnt    = drop_cnt;
        if (reg_wr) begin
            if (hit(reg_addr, pw_encap_pkg::REG_CTRL))    next_ctrl = reg_wdata;
            if (hit(reg_addr, pw_encap_pkg::REG_PAYLOAD)) next_payload_len = reg_wdata[15:0];
            if (hit(reg_addr, pw_encap_pkg::REG_MTU))     next_mtu = reg_wdata[15:0];
            if (hit(reg_addr, pw_encap_pkg::REG_RTP_ID))  next_ssrc = reg_wdata;
            if (hit(reg_addr, pw_encap_pkg::REG_SEQ))     next_seq = reg_wdata[15:0];
        end
        // Hardware increment wins over a software write in the same cycle
        if (state == ST_PAY && tx_ready && rd_ptr == pay_words[7:0] - 8'h01) begin
            next_seq     = seq + 16'h0001;
            next_pkt_cnt = pkt_cnt + 16'h0001;
        end
        if (state == ST_DROP) begin
            next_drop_cnt = drop_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl        <= pw_encap_pkg::CTRL_RESET;
            payload_len <= pw_encap_pkg::PAYLOAD_RESET;
            mtu         <= pw_encap_pkg::MTU_RESET;
            ssrc        <= 32'h0000_0000;
            seq         <= 16'h0000;
            pkt_cnt     <= 16'h0000;
            drop_cnt    <= 16'h0000;
        end else begin
            ctrl        <= next_ctrl;
            payload_len <= next_payload_len;
            mtu         <= next_mtu;
            ssrc        <= next_ssrc;
            seq         <= next_seq;
            pkt_cnt     <= next_pkt_cnt;
            drop_cnt    <= next_drop_cnt;
        end
    end

    // Read data stand the cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend   <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            rd_pend   <= reg_rd;
            rd_addr_q <= reg_addr;
        end
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        if (rd_pend) begin
            case (rd_addr_q)
                pw_encap_pkg::REG_CTRL:    reg_rdata = ctrl;
                pw_encap_pkg::REG_PAYLOAD: reg_rdata = {16'h0000, payload_len};
                pw_encap_pkg::REG_MTU:     reg_rdata = {16'h0000, mtu};
                pw_encap_pkg::REG_RTP_ID:  reg_rdata = ssrc;
                pw_encap_pkg::REG_SEQ:     reg_rdata = {16'h0000, seq};
                pw_encap_pkg::REG_STATUS:  reg_rdata = {28'h0000000, alarm_detected,
                    fits_mtu, state};
                pw_encap_pkg::REG_PKTCNT:  reg_rdata = {drop_cnt, pkt_cnt};
                default:                   reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Packing: first bit of the circuit lands in the top bit of each byte
    always_comb begin
        next_state    = state;
        next_fill_cnt = fill_cnt;
        next_shreg    = shreg;
        next_rd_ptr   = rd_ptr;
        next_hidx     = hidx;
        next_tstamp_q = tstamp_q;
        wr_en         = 1'b0;
        wr_ptr        = fill_cnt[9:2];
        wr_word       = {shreg, tdm_byte};
        case (state)
            ST_FILL: begin
                if (tdm_valid && tdm_ready) begin
                    next_shreg    = {shreg[15:0], tdm_byte};
                    next_fill_cnt = fill_cnt + 16'h0001;
                    wr_en         = (fill_cnt[1:0] == 2'h3) || pkt_done;
                    case (fill_cnt[1:0])
                        2'h0: wr_word = {tdm_byte, 24'h000000};
                        2'h1: wr_word = {shreg[7:0], tdm_byte, 16'h0000};
                        2'h2: wr_word = {shreg[15:0], tdm_byte, 8'h00};
                        default: wr_word = {shreg, tdm_byte};
                    endcase
                    if (pkt_done) begin
                        next_fill_cnt = 16'h0000;
                        next_hidx     = 3'h0;
                        next_tstamp_q = tstamp_in;
                        next_state    = fits_mtu ? ST_HDR : ST_DROP;
                    end
                end
            end
            ST_HDR: begin
                if (tx_ready) begin
                    next_hidx = hidx + 3'h1;
                    if (hidx == hdr.hdr_words - 3'h1) begin
                        next_rd_ptr = 8'h00;
                        next_state  = ST_PAY;
                    end
                end
            end
            ST_PAY: begin
                if (tx_ready) begin
                    next_rd_ptr = rd_ptr + 8'h01;
                    if (rd_ptr == pay_words[7:0] - 8'h01) begin
                        next_state = ST_FILL;
                    end
                end
            end
            ST_DROP: next_state = ST_FILL;
            default: next_state = ST_FILL;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_FILL;
            fill_cnt <= 16'h0000;
            shreg    <= 24'h000000;
            rd_ptr   <= 8'h00;
            hidx     <= 3'h0;
            tstamp_q <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            fill_cnt <= next_fill_cnt;
            shreg    <= next_shreg;
            rd_ptr   <= next_rd_ptr;
            hidx     <= next_hidx;
            tstamp_q <= next_tstamp_q;
        end
    end

    // Payload memory write port
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            pay_mem[wr_ptr] <= wr_word;
        end
    end

    // Output stream: header words then payload words
    always_comb begin
        tx_valid = (state == ST_HDR) || (state == ST_PAY);
        tx_data  = (state == ST_HDR) ? hdr.word : pay_mem[rd_ptr];
        tx_first = (state == ST_HDR) && (hidx == 3'h0);
        tx_last  = (state == ST_PAY) && (rd_ptr == pay_words[7:0] - 8'h01);
    end

    // Checks on the emitted stream
    property p_seq_step;
        @(posedge ref_clk) disable iff (!resetn)
        (tx_valid && tx_ready && tx_last && !reg_wr) |=> (seq == $past(seq) + 16'h0001);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("seq not stepped");

    property p_mtu;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR) |-> fits_mtu;
    endproperty
    a_mtu: assert property (p_mtu) else $error("oversize packet sent");

    property p_spare;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR && !hdr.rtp_on) |-> (tx_data[25:22] == 4'h0);
    endproperty
    a_spare: assert property (p_spare) else $error("spare bits nonzero");

    property p_lead;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR && !hdr.rtp_on && !hdr.ach_en) |-> (tx_data[31:28] == 4'h0);
    endproperty
    a_lead: assert property (p_lead) else $error("leading bits nonzero");

    property p_short;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR && !hdr.rtp_on && pkt_bytes >= pw_encap_pkg::SHORT_LIMIT)
            |-> (tx_data[21:16] == 6'h00);
    endproperty
    a_short: assert property (p_short) else $error("short size not zero");

    property p_df;
        @(posedge ref_clk) disable iff (!resetn)
        ctrl[pw_encap_pkg::CTRL_IPV4] |-> dont_fragment;
    endproperty
    a_df: assert property (p_df) else $error("df not set");

    sequence s_udp_rtp_start;
        state == ST_HDR && hidx == 3'h0 && hdr.rtp_on && hdr.demux == pw_encap_pkg::DEMUX_UDP;
    endsequence
    property p_udp_order;
        @(posedge ref_clk) disable iff (!resetn)
        s_udp_rtp_start |-> (tx_data[31:30] == pw_encap_pkg::RTP_VERSION);
    endproperty
    a_udp_order: assert property (p_udp_order) else $error("rtp not first");

    property p_mpls_order;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR && hidx == 3'h1 && hdr.rtp_on && hdr.demux != pw_encap_pkg::DEMUX_UDP)
            |-> (tx_data[15:0] == seq && tx_data[31:30] == pw_encap_pkg::RTP_VERSION);
    endproperty
    a_mpls_order: assert property (p_mpls_order) else $error("rtp not after cw");

    property p_hdr_len;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ST_HDR && hidx == 3'h0) |-> (hdr.hdr_words == (hdr.rtp_on ? 3'h4 : 3'h1));
    endproperty
    a_hdr_len: assert property (p_hdr_len) else $error("header length wrong");
endmodule // pw_encapsulator
`default_nettype wire

// ### tb/pkt_sink.sv
/* Packet network sink model: takes header and payload words from the framer.
   Assumes ref_clk is shared with the framer; slow makes it stall every other cycle. */
`default_nettype none
module pkt_sink (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    input  wire logic        tx_first,
    input  wire logic        tx_last,
    output logic             tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [33:0] mem [0:511];
    int          n;
    int          pkts;
    // Words are kept raw; spare and split bits are never interpreted
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            n <= 0;
            pkts <= 0;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                mem[n] <= {tx_first, tx_last, tx_data};
                n <= n + 1;
                if (tx_last)
                    pkts <= pkts + 1;
            end
        end
    end
endmodule // pkt_sink
`default_nettype wire

// ### tb/tb_top.sv
/* Self-checking bench for the framer: table of configurations, then MTU, wrap and reset.
   Assumes the packet side is the pkt_sink model. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] ctrl; logic [15:0] plen; logic [7:0] fill;} row_t;
    logic        ref_clk, resetn, reg_wr, reg_rd, tdm_valid, tdm_ready, slow;
    logic [7:0]  reg_addr, tdm_byte;
    logic [31:0] reg_wdata, reg_rdata, tstamp_in, tx_data, rv;
    logic        tx_valid, tx_first, tx_last, tx_ready, dont_fragment, alarm_detected;
    logic [15:0] exp_seq;
    int          errors, tests_run, p;
    // Fill 00 means a counting byte pattern
    row_t rows [8] = '{'{32'h0000_2001, 16'd8, 8'h00}, '{32'h0060_0003, 16'd44, 8'h00},
        '{32'h0060_0017, 16'd48, 8'h00}, '{32'h0060_002B, 16'd6, 8'h00},
        '{32'h0000_11C1, 16'd60, 8'h00}, '{32'h0000_0031, 16'd8, 8'hFF},
        '{32'h0000_0001, 16'd8, 8'hFF}, '{32'h0000_0011, 16'd52, 8'h00}};
    pw_encapsulator dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tdm_valid(tdm_valid), .tdm_byte(tdm_byte), .tdm_ready(tdm_ready),
        .tstamp_in(tstamp_in), .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first),
        .tx_last(tx_last), .tx_ready(tx_ready), .dont_fragment(dont_fragment),
        .alarm_detected(alarm_detected));
    pkt_sink sink (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    function automatic logic [7:0] bv(input int k, input int plen, input logic [7:0] fill);
        return (k >= plen) ? 8'h00 : ((fill != 8'h00) ? fill : k[7:0]);
    endfunction
    task automatic send(input int plen, input logic [7:0] fill);
        int i;
        int g;
        i = 0;
        g = 0;
        tdm_valid <= 1'b1;
        tdm_byte <= bv(0, plen, fill);
        while (i < plen && g < 4000) begin
            @(posedge ref_clk);
            g++;
            if (tdm_ready) begin
                i++;
                tdm_byte <= bv(i, plen, fill);
            end
        end
        tdm_valid <= 1'b0;
        check("sent", 32'(i), 32'(plen));
    endtask
    // One packet: configure, feed payload, then compare every word the sink took
    task automatic pkt(input logic [31:0] c, input int plen, input logic [7:0] fill);
        int h, cwi, tot, n0, p0, j, g;
        logic [31:0] w;
        h = c[1] ? 4 : 1;
        cwi = (c[1] && c[3:2] == 2'h0) ? 3 : 0;
        tot = 4 * h + plen;
        n0 = sink.n;
        p0 = sink.pkts;
        g = 0;
        wr(8'h00, c);
        wr(8'h04, 32'(plen));
        tstamp_in <= {16'hA5A5, exp_seq};
        send(plen, fill);
        while (sink.pkts == p0 && g < 4000) begin
            @(posedge ref_clk);
            g++;
        end
        #1 w = sink.mem[n0 + cwi][31:0];
        check("pkt_done", 32'(sink.pkts - p0), 32'h0000_0001);
        check("words", 32'(sink.n - n0), 32'(h + (plen + 3) / 4));
        check("cw_lead", w[31:28], c[12] ? c[11:8] : 4'h0);
        check("cw_flags", w[27:26], {c[6], c[7]});
        check("cw_spare", w[25:22], 4'h0);
        check("cw_short", w[21:16], (tot < 64) ? 32'(tot) : 32'h0);
        check("cw_seq", w[15:0], exp_seq);
        if (h == 4) begin
            j = (cwi == 3) ? 0 : 1;
            check("rtp0", sink.mem[n0 + j][31:0], {4'h8, 5'h00, c[22:16], exp_seq});
            check("rtp_ts", sink.mem[n0 + j + 1][31:0], {16'hA5A5, exp_seq});
            check("rtp_ssrc", sink.mem[n0 + j + 2][31:0], 32'h5A17_0001);
        end
        for (j = 0; j < (plen + 3) / 4; j++)
            check("payload", sink.mem[n0 + h + j][31:0], {bv(4 * j, plen, fill),
                bv(4 * j + 1, plen, fill), bv(4 * j + 2, plen, fill),
                bv(4 * j + 3, plen, fill)});
        check("first", sink.mem[n0][33], 1'b1);
        check("last", sink.mem[sink.n - 1][32], 1'b1);
        check("dont_frag", dont_fragment, c[13]);
        check("alarm", alarm_detected, fill == 8'hFF && c[5:4] != 2'h3);
        exp_seq = exp_seq + 16'h0001;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Watchdog: whole run needs well under this many cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        complete_run;
    end
    initial begin
        {resetn, reg_wr, reg_rd, tdm_valid, slow} = 5'h00;
        {reg_addr, tdm_byte, reg_wdata, tstamp_in} = 80'h0;
        {errors, tests_run, exp_seq} = 80'h0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        wr(8'h0C, 32'h5A17_0001);
        for (int k = 0; k < 8; k++) begin
            slow <= k[0];
            pkt(rows[k].ctrl, 32'(rows[k].plen), rows[k].fill);
        end
        // One byte over the limit is dropped; exactly at the limit goes out
        wr(8'h08, 32'h0000_0027);
        p = sink.pkts;
        wr(8'h04, 32'h0000_0008);
        send(8, 8'h00);
        repeat (40) @(posedge ref_clk);
        check("mtu_drop", 32'(sink.pkts), 32'(p));
        wr(8'h08, 32'h0000_0028);
        wr(8'h10, 32'h0000_FFFF);
        exp_seq = 16'hFFFF;
        pkt(32'h0000_0001, 8, 8'h00);
        pkt(32'h0000_0001, 8, 8'h00);
        // Ten packets sent, one dropped; idle status shows fit and no alarm
        rd(8'h18, rv);
        check("pkt_cnt", rv, 32'h0001_000A);
        rd(8'h14, rv);
        check("status", rv, 32'h0000_0004);
        rd(8'h10, rv);
        check("seq_rd", rv, 32'h0000_0001);
        // Mid-run reset, then defaults and an unmapped place
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(8'h10, rv);
        check("seq_rst", rv, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, rv);
        check("unmapped", rv, 32'h0000_0000);
        rd(8'h00, rv);
        check("ctrl_rst", rv, 32'h0000_0000);
        rd(8'h04, rv);
        check("payload_rst", rv, 32'h0000_0100);
        rd(8'h08, rv);
        check("mtu_rst", rv, 32'h0000_05DC);
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
